// file: lcell_pkg.sv
// shared constants and types of the programmable logic cell
package lcell_pkg;

    // register word indexes on the plain configuration port
    localparam logic [3:0]  ADDR_MASK   = 4'h0;
    localparam logic [3:0]  ADDR_CFG    = 4'h1;
    localparam logic [3:0]  ADDR_STATUS = 4'h2;

    // reset values
    localparam logic [15:0] MASK_RST    = 16'h0000;
    localparam logic [16:0] CFG_RST     = 17'h00001;

    // configuration field positions
    localparam int CFG_MODE_LSB  = 0;
    localparam int CFG_CIN_SEL   = 3;
    localparam int CFG_CASC_EN   = 4;
    localparam int CFG_CE_USE_A  = 5;
    localparam int CFG_FFSRC_LSB = 6;
    localparam int CFG_TAP_LSB   = 8;
    localparam int CFG_ROUTE_LSB = 11;
    localparam int CFG_CP_LSB    = 13;
    localparam int CFG_CHIP_EN   = 16;

    // status field positions
    localparam int ST_Q       = 0;
    localparam int ST_LOCAL   = 1;
    localparam int ST_GLOBAL  = 2;
    localparam int ST_CARRY   = 3;
    localparam int ST_CASCADE = 4;

    typedef enum logic [2:0] {
        LCELL_NORMAL = 3'b001,
        LCELL_ARITH  = 3'b010,
        LCELL_UPDOWN = 3'b100
    } lcell_mode_t;

    // flip-flop data source in normal mode
    typedef enum logic [1:0] {
        LCELL_FF_LUT    = 2'h0,
        LCELL_FF_DIRECT = 2'h1,
        LCELL_FF_TAP    = 2'h2
    } lcell_ffsrc_t;

    // which value reaches local and global routing
    typedef enum logic [1:0] {
        LCELL_RT_COMB     = 2'h0,
        LCELL_RT_REG      = 2'h1,
        LCELL_RT_PACK_LG  = 2'h2,
        LCELL_RT_PACK_GL  = 2'h3
    } lcell_route_t;

    // six clear/preset configurations
    typedef enum logic [2:0] {
        LCELL_CP_NONE = 3'h0,
        LCELL_CP_CLR  = 3'h1,
        LCELL_CP_PRE  = 3'h2,
        LCELL_CP_BOTH = 3'h3,
        LCELL_CP_LOAD = 3'h4,
        LCELL_CP_INV  = 3'h5
    } lcell_cp_t;

endpackage

// file: lcell_lut_if.sv
// look-up function request and result bundle
`timescale 1ns/1ps
`default_nettype none
interface lcell_lut_if;
    logic [15:0] mask;
    logic [3:0]  idx4;
    logic [2:0]  idx3;
    logic        out4;
    logic        out_lo;
    logic        out_hi;

    modport user (output mask, output idx4, output idx3, input out4, input out_lo, input out_hi);
    modport lut  (input mask, input idx4, input idx3, output out4, output out_lo, output out_hi);
endinterface
`default_nettype wire

// file: lcell_lut.sv
// four-input look-up and its two three-input halves
`timescale 1ns/1ps
`default_nettype none
module lcell_lut
(
    lcell_lut_if.lut lut_bus
);
    function automatic logic lcell_pick(input logic [15:0] m, input logic [3:0] i);
        lcell_pick = m[i];
    endfunction

    // full table
    assign lut_bus.out4   = lcell_pick(lut_bus.mask, lut_bus.idx4);
    // low half: sum or count bit
    assign lut_bus.out_lo = lcell_pick({8'h00, lut_bus.mask[7:0]}, {1'b0, lut_bus.idx3});
    // high half: carry bit
    assign lut_bus.out_hi = lcell_pick({8'h00, lut_bus.mask[15:8]}, {1'b0, lut_bus.idx3});
endmodule
`default_nettype wire

// file: lcell_top.sv
// programmable logic cell: look-up, flip-flop, chains and packing
// Function
// - normal mode: four-input lookup, carry-in or input c
// - lookup combined with cascade-in onto cascade-out
// - register or lookup drives both routings
// - packing: input d loads register, three-input lookup
// - one lookup input may also feed register
// - packed register keeps enable, clear and preset
// - packed: register global and lookup local, or swapped
// - arithmetic: first three-input half gives sum
// - arithmetic: second half gives carry-out
// - cascade chain usable alongside carry chain
// - counter controls from inputs, carry, feedback
// - counter: count-bit half and fast-carry half
// - counter: selector picks count or load value
// - asynchronous load through clear and preset
// - six clear/preset modes; chip reset overrides
// - chip reset presets via inverted clear path
// - synchronous clock enable, input a optional
// - dedicated clock, clear and preset inputs
`timescale 1ns/1ps
`default_nettype none
module lcell_top
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [3:0]  cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    output var  logic [31:0] cfg_rdata,
    input  wire logic        cell_input_a,
    input  wire logic        cell_input_b,
    input  wire logic        cell_input_c,
    input  wire logic        cell_input_d,
    input  wire logic        carry_in,
    input  wire logic        cascade_in,
    input  wire logic        cell_clk,
    input  wire logic        cell_clear,
    input  wire logic        cell_preset,
    input  wire logic        chip_reset_n,
    output logic             local_out,
    output logic             global_out,
    output logic             carry_out,
    output logic             cascade_out
);
    logic [15:0]           lut_mask;
    logic [16:0]           cfg;
    logic                  clk_s1;
    logic                  clk_s2;
    logic                  clk_s3;
    logic                  p_reg;
    lcell_pkg::lcell_mode_t  mode;
    lcell_pkg::lcell_ffsrc_t ff_src;
    lcell_pkg::lcell_route_t route;
    lcell_pkg::lcell_cp_t    cp_mode;
    logic                  cin_sel;
    logic                  casc_en;
    logic                  ce_use_a;
    logic [1:0]            tap_sel;
    logic                  chip_en;

    lcell_lut_if lut_bus ();

    lcell_lut u_lut
    (
        .lut_bus (lut_bus)
    );

    // configuration port decode
    wire wr_mask = cfg_wr && (cfg_addr == lcell_pkg::ADDR_MASK);
    wire wr_cfg  = cfg_wr && (cfg_addr == lcell_pkg::ADDR_CFG);

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            lut_mask <= lcell_pkg::MASK_RST;
            cfg      <= lcell_pkg::CFG_RST;
        end
        else
        begin
            if (wr_mask)
                lut_mask <= cfg_wdata[15:0];
            if (wr_cfg)
                cfg <= cfg_wdata[16:0];
        end
    end

    assign mode     = lcell_pkg::lcell_mode_t'(cfg[lcell_pkg::CFG_MODE_LSB +: 3]);
    assign cin_sel  = cfg[lcell_pkg::CFG_CIN_SEL];
    assign casc_en  = cfg[lcell_pkg::CFG_CASC_EN];
    assign ce_use_a = cfg[lcell_pkg::CFG_CE_USE_A];
    assign ff_src   = lcell_pkg::lcell_ffsrc_t'(cfg[lcell_pkg::CFG_FFSRC_LSB +: 2]);
    assign tap_sel  = cfg[lcell_pkg::CFG_TAP_LSB +: 2];
    assign route    = lcell_pkg::lcell_route_t'(cfg[lcell_pkg::CFG_ROUTE_LSB +: 2]);
    assign cp_mode  = lcell_pkg::lcell_cp_t'(cfg[lcell_pkg::CFG_CP_LSB +: 3]);
    assign chip_en  = cfg[lcell_pkg::CFG_CHIP_EN];

    // cell clock arrives from routing: synchronise, then find rising edge
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
        end
        else
        begin
            clk_s1 <= cell_clk;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
        end
    end

    wire clk_edge = clk_s2 && !clk_s3;

    // decoded mode flags
    wire is_arith  = (mode == lcell_pkg::LCELL_ARITH);
    wire is_updown = (mode == lcell_pkg::LCELL_UPDOWN);
    wire is_normal = !is_arith && !is_updown;
    wire packed3   = is_normal && (ff_src == lcell_pkg::LCELL_FF_DIRECT);
    wire inv       = (cp_mode == lcell_pkg::LCELL_CP_INV);

    // lookup inputs
    wire       third_in = cin_sel ? carry_in : cell_input_c;
    wire [3:0] idx4     = {cell_input_d && !packed3, third_in, cell_input_b, cell_input_a};
    wire [2:0] idx3_ar  = {carry_in, cell_input_c, cell_input_b};
    // counter feedback from the stored bit, through the inversion option
    wire       local_q  = p_reg ^ inv;
    wire [2:0] idx3_ud  = {carry_in, cell_input_b, local_q};

    assign lut_bus.mask = lut_mask;
    assign lut_bus.idx4 = idx4;
    assign lut_bus.idx3 = is_updown ? idx3_ud : idx3_ar;

    // combinational result of the cell
    wire comb = is_normal ? lut_bus.out4 : lut_bus.out_lo;

    // flip-flop data path
    wire tap_bit  = idx4[tap_sel];
    wire norm_d   = (ff_src == lcell_pkg::LCELL_FF_DIRECT) ? cell_input_d :
                    (ff_src == lcell_pkg::LCELL_FF_TAP)    ? tap_bit      :
                    lut_bus.out4;
    wire count_d  = cell_input_d ? cell_input_c : lut_bus.out_lo;
    wire data_d   = is_arith ? lut_bus.out_lo : is_updown ? count_d : norm_d;
    wire next_p   = data_d ^ inv;
    wire clk_en   = ce_use_a ? cell_input_a : 1'b1;

    // asynchronous controls per clear/preset configuration
    logic clr_phys;
    logic pre_phys;
    always_comb
    begin
        clr_phys = 1'b0;
        pre_phys = 1'b0;
        case (cp_mode)
            lcell_pkg::LCELL_CP_NONE:
            begin
                clr_phys = 1'b0;
                pre_phys = 1'b0;
            end
            lcell_pkg::LCELL_CP_CLR:  clr_phys = cell_clear;
            lcell_pkg::LCELL_CP_PRE:  pre_phys = cell_preset;
            lcell_pkg::LCELL_CP_BOTH:
            begin
                clr_phys = cell_clear;
                pre_phys = cell_preset;
            end
            lcell_pkg::LCELL_CP_LOAD:
            begin
                clr_phys = cell_clear && !cell_input_c;
                pre_phys = cell_clear && cell_input_c;
            end
            lcell_pkg::LCELL_CP_INV:
            begin
                clr_phys = cell_preset;
                pre_phys = cell_clear;
            end
            default:
            begin
                clr_phys = 1'b0;
                pre_phys = 1'b0;
            end
        endcase
    end

    wire chip_act = chip_en && !chip_reset_n;
    wire p_clr    = chip_act || clr_phys;
    wire p_set    = !chip_act && !clr_phys && pre_phys;
    wire p_view   = p_clr ? 1'b0 : (p_set ? 1'b1 : p_reg);
    wire q        = p_view ^ inv;

    always_ff @(posedge mclk)
    begin
        if (!resetn)
            p_reg <= 1'b0;
        else if (p_clr)
            p_reg <= 1'b0;
        else if (p_set)
            p_reg <= 1'b1;
        else if (clk_edge && clk_en)
            p_reg <= next_p;
    end

    // output routing
    always_comb
    begin
        case (route)
            lcell_pkg::LCELL_RT_COMB:
            begin
                local_out  = comb;
                global_out = comb;
            end
            lcell_pkg::LCELL_RT_REG:
            begin
                local_out  = q;
                global_out = q;
            end
            lcell_pkg::LCELL_RT_PACK_LG:
            begin
                local_out  = comb;
                global_out = q;
            end
            default:
            begin
                local_out  = q;
                global_out = comb;
            end
        endcase
    end

    assign cascade_out = casc_en ? (comb && cascade_in) : comb;
    assign carry_out   = is_normal ? 1'b0 : lut_bus.out_hi;

    // status and read-back, one cycle after the read strobe
    wire [31:0] status = {27'h0000000, cascade_out, carry_out, global_out, local_out, q};
    wire [31:0] rd_mux = (cfg_addr == lcell_pkg::ADDR_MASK)   ? {16'h0000, lut_mask} :
                         (cfg_addr == lcell_pkg::ADDR_CFG)    ? {15'h0000, cfg}      :
                         (cfg_addr == lcell_pkg::ADDR_STATUS) ? status               :
                         32'h00000000;

    always_ff @(posedge mclk)
    begin
        if (!resetn)
            cfg_rdata <= 32'h00000000;
        else if (cfg_rd)
            cfg_rdata <= rd_mux;
        else
            cfg_rdata <= 32'h00000000;
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    wire quiet = !p_clr && !p_set;

    chk_cascade_gate: assert property (casc_en && !cascade_in |-> !cascade_out)
        else $error("cascade-out high while cascade-in low");
    chk_route_reg: assert property (route == lcell_pkg::LCELL_RT_REG |-> local_out == q && global_out == q)
        else $error("register not on both routings");
    chk_pack_split: assert property (route == lcell_pkg::LCELL_RT_PACK_GL |-> local_out == q && global_out == comb)
        else $error("packed swap routing wrong");
    chk_direct_load: assert property (packed3 && !inv && clk_edge && clk_en && quiet ##1 quiet |-> q == $past(cell_input_d))
        else $error("direct input not registered");
    chk_ce_hold: assert property (!(clk_edge && clk_en) && quiet |=> p_reg == $past(p_reg))
        else $error("register changed without enable");
    chk_clear_now: assert property (cp_mode == lcell_pkg::LCELL_CP_CLR && cell_clear |-> q == 1'b0)
        else $error("clear not immediate");
    chk_count_load: assert property (is_updown && !inv && cell_input_d && clk_edge && clk_en && quiet ##1 quiet |-> q == $past(cell_input_c))
        else $error("counter load value lost");
    chk_arith_sum: assert property (is_arith && lut_mask == 16'hE896 |-> comb == (cell_input_b ^ cell_input_c ^ carry_in) && carry_out == ((cell_input_b & cell_input_c) | (carry_in & (cell_input_b | cell_input_c))))
        else $error("adder halves wrong");
    chk_chip_wins: assert property (chip_act |-> q == inv)
        else $error("chip reset did not override");
    chk_inv_preset: assert property (inv && cell_preset && !chip_act |-> q == 1'b1 ##1 q == 1'b1 || cell_clear || !cell_preset)
        else $error("inverted preset failed");

    // tap, async load, chain, routing and read-port checks
    wire tap_cap   = is_normal && (ff_src == lcell_pkg::LCELL_FF_TAP) && !inv
                     && clk_edge && clk_en && quiet;
    wire ld_strobe = (cp_mode == lcell_pkg::LCELL_CP_LOAD) && cell_clear && !chip_act;

    chk_tap_load: assert property (tap_cap ##1 quiet |-> q == $past(tap_bit))
        else $error("tapped input not registered");
    chk_async_load: assert property (ld_strobe |-> q == cell_input_c)
        else $error("asynchronous load value lost");
    chk_casc_off: assert property (!casc_en |-> cascade_out == comb)
        else $error("cascade-out differs from lookup");
    chk_route_comb: assert property (route == lcell_pkg::LCELL_RT_COMB |->
        local_out == comb && global_out == comb)
        else $error("lookup not on both routings");
    chk_rdata_idle: assert property (!cfg_rd |=> cfg_rdata == 32'h00000000)
        else $error("read data outside its slot");

    cov_arith_chain: cover property (is_arith && casc_en && carry_out && cascade_out);
    cov_count_load:  cover property (is_updown && cell_input_d && clk_edge && clk_en);
    cov_pack_cap:    cover property (packed3 && clk_edge && clk_en ##1 route == lcell_pkg::LCELL_RT_PACK_LG);
    cov_chip_reset:  cover property (chip_act && inv);
    cov_async_load:  cover property (ld_strobe);
endmodule
`default_nettype wire

// file: lcell_fabric.sv
// routed cell clock source standing in for the surrounding fabric
`timescale 1ns/1ps
`default_nettype none
module lcell_fabric
(
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic go,
    output logic      cell_clk
);
    logic [2:0] cnt;
    // three cycles high, three low, then stands still low
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            cnt <= 3'h0;
        else if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
        else if (go)
            cnt <= 3'h6;
    end
    assign cell_clk = (cnt > 3'h3);
endmodule
`default_nettype wire

// file: lcell_top_tb.sv
// self-checking bench of the programmable logic cell
`timescale 1ns/1ps
`default_nettype none
module lcell_top_tb;
    logic        mclk;
    logic        resetn;
    logic [3:0]  cfg_addr;
    logic [31:0] cfg_wdata;
    logic        cfg_wr;
    logic        cfg_rd;
    logic [31:0] cfg_rdata;
    logic [3:0]  dcba;
    logic        carry_in;
    logic        cascade_in;
    logic        cell_clk;
    logic        cell_clear;
    logic        cell_preset;
    logic        chip_reset_n;
    logic        go;
    logic        local_out;
    logic        global_out;
    logic        carry_out;
    logic        cascade_out;
    logic [31:0] rd_val;
    int          failures;
    int          samples_checked;

    localparam logic [15:0] NORM_MASK = 16'hA5C3;

    lcell_fabric fab (.mclk(mclk), .resetn(resetn), .go(go), .cell_clk(cell_clk));

    lcell_top uut
    (
        .mclk(mclk), .resetn(resetn), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
        .cell_input_a(dcba[0]), .cell_input_b(dcba[1]), .cell_input_c(dcba[2]),
        .cell_input_d(dcba[3]), .carry_in(carry_in), .cascade_in(cascade_in),
        .cell_clk(cell_clk), .cell_clear(cell_clear), .cell_preset(cell_preset),
        .chip_reset_n(chip_reset_n), .local_out(local_out), .global_out(global_out),
        .carry_out(carry_out), .cascade_out(cascade_out)
    );

    task automatic stop_test();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] cw(input logic [2:0] m, input logic [2:0] fl,
        input logic [1:0] src, input logic [1:0] tap, input logic [1:0] rt,
        input logic [2:0] cp, input logic ch);
        return {15'h0000, ch, cp, rt, 1'b0, tap, src, fl, m};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        cfg_addr  <= a;
        cfg_wdata <= d;
        cfg_wr    <= 1'b1;
        @(posedge mclk);
        cfg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        cfg_addr <= a;
        cfg_rd   <= 1'b1;
        @(posedge mclk);
        cfg_rd   <= 1'b0;
        #1;
        rd_val = cfg_rdata;
    endtask

    task automatic drv(input logic [3:0] v, input logic ci, input logic cs);
        @(posedge mclk);
        dcba       <= v;
        carry_in   <= ci;
        cascade_in <= cs;
        #1;
    endtask

    task automatic ctl(input logic cl, input logic pr, input logic crn);
        @(posedge mclk);
        cell_clear   <= cl;
        cell_preset  <= pr;
        chip_reset_n <= crn;
        #1;
    endtask

    // one routed clock pulse, then time for the capture to land
    task automatic pulse();
        @(posedge mclk);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (8) @(posedge mclk);
        #1;
    endtask

    task automatic t_regs();
        rd(lcell_pkg::ADDR_MASK);
        chk32("mask reset", {16'h0000, lcell_pkg::MASK_RST}, rd_val);
        rd(lcell_pkg::ADDR_CFG);
        chk32("cfg reset", {15'h0000, lcell_pkg::CFG_RST}, rd_val);
        wr(4'hF, 32'hFFFF_FFFF);
        rd(4'hF);
        chk32("unmapped", 32'h0000_0000, rd_val);
        wr(lcell_pkg::ADDR_MASK, 32'hFFFF_A5C3);
        rd(lcell_pkg::ADDR_MASK);
        chk32("mask", 32'h0000_A5C3, rd_val);
        @(posedge mclk);
        #1;
        chk32("rdata idle", 32'h0000_0000, cfg_rdata);
    endtask

    // lookup index from input c, then from carry-in with c inverted
    task automatic t_normal();
        logic [3:0] v;
        logic       e;
        logic       q;
        for (int p = 0; p < 2; p++)
        begin
            q = p[0];
            wr(lcell_pkg::ADDR_CFG, cw(3'b001, {1'b0, q, q}, 2'h0, 2'h0, 2'h0, 3'h0, 1'b0));
            for (int i = 0; i < 16; i++)
            begin
                v = i[3:0];
                e = NORM_MASK[v];
                drv({v[3], v[2] ^ q, v[1:0]}, v[2] ^ ~q, v[0] ^ v[3]);
                chk1("local comb", e, local_out);
                chk1("global comb", e, global_out);
                chk1("carry normal", 1'b0, carry_out);
                chk1("cascade", e & (~q | (v[0] ^ v[3])), cascade_out);
            end
        end
    endtask

    task automatic t_arith();
        logic [2:0] v;
        wr(lcell_pkg::ADDR_MASK, 32'h0000_E896);
        wr(lcell_pkg::ADDR_CFG, cw(3'b010, 3'b010, 2'h0, 2'h0, 2'h0, 3'h0, 1'b0));
        for (int i = 0; i < 8; i++)
        begin
            v = i[2:0];
            drv({1'b0, v[1:0], 1'b0}, v[2], 1'b1);
            chk1("sum", ^v, local_out);
            chk1("carry", (v[0] & v[1]) | (v[2] & (v[0] | v[1])), carry_out);
            chk1("cascade arith", ^v, cascade_out);
        end
    endtask

    task automatic t_ff();
        wr(lcell_pkg::ADDR_MASK, 32'h0000_A5C3);
        wr(lcell_pkg::ADDR_CFG, cw(3'b001, 3'b100, 2'h1, 2'h0, 2'h2, 3'h0, 1'b0));
        drv(4'b1100, 1'b0, 1'b0);
        pulse();
        chk1("enable low", 1'b0, global_out);
        drv(4'b1101, 1'b0, 1'b0);
        pulse();
        chk1("captured", 1'b1, global_out);
        chk1("packed comb", 1'b0, local_out);
        wr(lcell_pkg::ADDR_CFG, cw(3'b001, 3'b100, 2'h1, 2'h0, 2'h3, 3'h0, 1'b0));
        #1;
        chk1("swap local", 1'b1, local_out);
        chk1("swap global", 1'b0, global_out);
        rd(lcell_pkg::ADDR_STATUS);
        chk32("status", 32'h0000_0003, rd_val);
        wr(lcell_pkg::ADDR_CFG, cw(3'b001, 3'b000, 2'h2, 2'h2, 2'h2, 3'h0, 1'b0));
        drv(4'b1001, 1'b0, 1'b0);
        pulse();
        chk1("tap comb", 1'b0, local_out);
        chk1("tap reg", 1'b0, global_out);
    endtask

    task automatic t_async();
        wr(lcell_pkg::ADDR_CFG, cw(3'b001, 3'b000, 2'h1, 2'h0, 2'h2, 3'h1, 1'b0));
        drv(4'b1000, 1'b0, 1'b0);
        pulse();
        ctl(1'b1, 1'b0, 1'b1);
        chk1("clear", 1'b0, global_out);
        ctl(1'b0, 1'b1, 1'b1);
        chk1("preset unused", 1'b0, global_out);
        wr(lcell_pkg::ADDR_CFG, cw(3'b001, 3'b000, 2'h1, 2'h0, 2'h2, 3'h3, 1'b0));
        ctl(1'b1, 1'b1, 1'b1);
        chk1("clear wins", 1'b0, global_out);
        ctl(1'b0, 1'b1, 1'b1);
        chk1("preset", 1'b1, global_out);
        ctl(1'b0, 1'b0, 1'b1);
        wr(lcell_pkg::ADDR_CFG, cw(3'b001, 3'b000, 2'h1, 2'h0, 2'h2, 3'h4, 1'b0));
        ctl(1'b1, 1'b0, 1'b1);
        chk1("load zero", 1'b0, global_out);
        drv(4'b1100, 1'b0, 1'b0);
        chk1("load one", 1'b1, global_out);
        ctl(1'b0, 1'b0, 1'b1);
        wr(lcell_pkg::ADDR_CFG, cw(3'b001, 3'b000, 2'h1, 2'h0, 2'h2, 3'h0, 1'b1));
        ctl(1'b0, 1'b0, 1'b0);
        chk1("chip reset", 1'b0, global_out);
        pulse();
        chk1("chip override", 1'b0, global_out);
        ctl(1'b0, 1'b0, 1'b1);
        wr(lcell_pkg::ADDR_CFG, cw(3'b001, 3'b000, 2'h1, 2'h0, 2'h2, 3'h5, 1'b1));
        ctl(1'b1, 1'b0, 1'b1);
        chk1("inv clear", 1'b0, global_out);
        ctl(1'b0, 1'b1, 1'b1);
        chk1("inv preset", 1'b1, global_out);
        ctl(1'b1, 1'b0, 1'b1);
        ctl(1'b0, 1'b0, 1'b0);
        chk1("chip preset", 1'b1, global_out);
        ctl(1'b0, 1'b0, 1'b1);
    endtask

    // count bit q^cin, carry cin and q (up) or not q (down)
    task automatic t_count();
        wr(lcell_pkg::ADDR_MASK, 32'h0000_905A);
        wr(lcell_pkg::ADDR_CFG, cw(3'b100, 3'b000, 2'h0, 2'h0, 2'h1, 3'h0, 1'b0));
        drv(4'b1110, 1'b0, 1'b0);
        pulse();
        chk1("load", 1'b1, local_out);
        drv(4'b0010, 1'b1, 1'b0);
        chk1("carry up", 1'b1, carry_out);
        pulse();
        chk1("count up", 1'b0, global_out);
        chk1("carry up low", 1'b0, carry_out);
        drv(4'b0000, 1'b1, 1'b0);
        chk1("carry down", 1'b1, carry_out);
        pulse();
        chk1("count down", 1'b1, local_out);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial
    begin
        failures = 0;
        samples_checked = 0;
        {resetn, cfg_wr, cfg_rd, go, cell_clear, cell_preset} = 6'h00;
        {cfg_addr, dcba, carry_in, cascade_in} = 10'h000;
        cfg_wdata = 32'h0000_0000;
        chip_reset_n = 1'b1;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        t_regs();
        t_normal();
        t_arith();
        t_ff();
        t_async();
        t_count();
        stop_test();
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
